// >>> include/opd_consts.svh
// constants for the output pre-driver control block
`ifndef OPD_CONSTS_SVH
`define OPD_CONSTS_SVH
`define OPD_NUM_CH 8
`define OPD_SAFETY_CH 5
`define OPD_SIDE_RST 1'b0
`define OPD_FET_RST 1'b0
`define OPD_GCC_EXT 2'b00
`define OPD_GCC_20MA 2'b01
`define OPD_GCC_5MA 2'b10
`define OPD_GCC_1MA 2'b11
`define OPD_TSW_GC_NS 100
`define OPD_CLK_PERIOD_NS 10
`define OPD_TSW_GC_CYC ((`OPD_TSW_GC_NS) / (`OPD_CLK_PERIOD_NS))
`endif

// >>> include/opd_pkg.sv
// types for the output pre-driver control block
package opd_pkg;
    typedef enum logic [1:0] {
        OPD_DRV_TRI = 2'b00,
        OPD_DRV_PULL_UP = 2'b01,
        OPD_DRV_PULL_DOWN = 2'b10
    } opd_drive_t;
    typedef struct packed {
        logic side_high;
        logic fet_p;
        logic out_en;
        logic src_soft;
        logic soft_on;
        logic [1:0] gcc;
    } opd_ch_cfg_t;
    typedef struct packed {
        logic pull_up_en;
        logic pull_down_en;
        logic [1:0] gcc;
    } opd_ch_drv_t;
endpackage

// >>> rtl/opd_sync3.sv
// three-stage pin synchroniser with agreement on the last two stages
`timescale 1ns/1ps
module opd_sync3 #(
    parameter int W = 8,
    parameter logic [W-1:0] RST = '1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // pin side
    input wire logic [W-1:0] async_i,
    // synchronous side
    output logic [W-1:0] sync_o
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    wire [W-1:0] agree = ~(s2_r ^ s3_r);
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s1_r <= RST;
            s2_r <= RST;
            s3_r <= RST;
            sync_o <= RST;
        end else begin
            s1_r <= async_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            sync_o <= (agree & s3_r) | (~agree & sync_o);
        end
    end
endmodule

// >>> rtl/opd_predriver.sv
// eight-channel output pre-driver control logic
`timescale 1ns/1ps
`include "opd_consts.svh"
module opd_predriver
    import opd_pkg::*;
#(
    parameter int NCH = `OPD_NUM_CH
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic external_reset_n_i,
    // configuration
    input wire logic [NCH-1:0] channel_side_select_i,
    input wire logic [NCH-1:0] fet_type_select_i,
    input wire logic [NCH-1:0] channel_output_enable_i,
    input wire logic [NCH-1:0] control_source_select_i,
    input wire logic [NCH-1:0] soft_on_command_i,
    input wire logic [2*NCH-1:0] gate_current_code_i,
    input wire logic cfg_write_i,
    // pins
    input wire logic [NCH-1:0] pin_on_control_n_i,
    input wire logic safety_enable_pin_i,
    // status
    input wire logic status_read_i,
    output logic safety_enable_level_o,
    output logic safety_disable_sticky_o,
    // gate drive
    output logic [NCH-1:0] gate_pull_up_o,
    output logic [NCH-1:0] gate_pull_down_o,
    output logic [NCH-1:0] gate_drive_oe_o,
    output logic [2*NCH-1:0] gate_current_sel_o,
    output logic [NCH-1:0] cfg_side_high_o,
    output logic [NCH-1:0] cfg_fet_p_o
);
    opd_ch_cfg_t cfg_r [NCH];
    logic [NCH-1:0] pin_n_s;
    logic [1:0] ctl_s;
    logic rst_all;
    logic safety_s;
    logic ext_rst_n_s;
    logic sticky_r;
    logic [NCH-1:0] eff_en;
    logic [NCH-1:0] fet_on;

    opd_sync3 #(.W(NCH), .RST({NCH{1'b1}})) u_pin_sync (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .async_i(pin_on_control_n_i),
        .sync_o(pin_n_s)
    );
    opd_sync3 #(.W(2), .RST(2'b01)) u_ctl_sync (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .async_i({safety_enable_pin_i, external_reset_n_i}),
        .sync_o(ctl_s)
    );
    assign safety_s = ctl_s[1];
    assign ext_rst_n_s = ctl_s[0];
    assign rst_all = srst_i | ~ext_rst_n_s;

    // per-channel decode
    function automatic logic chan_on(input opd_ch_cfg_t c, input logic pin_n);
        chan_on = c.src_soft ? c.soft_on : ~pin_n;
    endfunction

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            if (g == `OPD_SAFETY_CH) begin : g_safe
                assign eff_en[g] = cfg_r[g].out_en & safety_s;
            end else begin : g_norm
                assign eff_en[g] = cfg_r[g].out_en;
            end
            assign fet_on[g] = chan_on(cfg_r[g], pin_n_s[g]);
        end
    endgenerate

    // configuration registers, reset to low-side nfet and disabled
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < NCH; i++) begin
            if (rst_all) begin
                cfg_r[i] <= '{side_high: `OPD_SIDE_RST, fet_p: `OPD_FET_RST, out_en: 1'b0,
                              src_soft: 1'b0, soft_on: 1'b0, gcc: `OPD_GCC_EXT};
            end else if (cfg_write_i) begin
                cfg_r[i] <= '{side_high: channel_side_select_i[i],
                              fet_p: fet_type_select_i[i],
                              out_en: channel_output_enable_i[i],
                              src_soft: control_source_select_i[i],
                              soft_on: soft_on_command_i[i],
                              gcc: gate_current_code_i[2*i +: 2]};
            end
        end
    end

    // safety status; a new disable event wins over a readout clear
    always_ff @(posedge clk_i) begin
        if (rst_all) begin
            sticky_r <= 1'b0;
            safety_enable_level_o <= 1'b0;
        end else begin
            safety_enable_level_o <= safety_s;
            if (cfg_r[`OPD_SAFETY_CH].out_en & ~safety_s) begin
                sticky_r <= 1'b1;
            end else if (status_read_i) begin
                sticky_r <= 1'b0;
            end
        end
    end
    assign safety_disable_sticky_o = sticky_r;

    // gate drive outputs, registered; current code passes in one cycle
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < NCH; i++) begin
            if (rst_all) begin
                gate_drive_oe_o[i] <= 1'b0;
                gate_pull_up_o[i] <= 1'b0;
                gate_pull_down_o[i] <= 1'b0;
                gate_current_sel_o[2*i +: 2] <= `OPD_GCC_EXT;
                cfg_side_high_o[i] <= `OPD_SIDE_RST;
                cfg_fet_p_o[i] <= `OPD_FET_RST;
            end else begin
                gate_drive_oe_o[i] <= eff_en[i];
                // nfet charges gate to turn on; pfet pulls gate down to turn on
                gate_pull_up_o[i] <= eff_en[i] & (fet_on[i] ^ cfg_r[i].fet_p);
                gate_pull_down_o[i] <= eff_en[i] & ~(fet_on[i] ^ cfg_r[i].fet_p);
                gate_current_sel_o[2*i +: 2] <= cfg_r[i].gcc;
                cfg_side_high_o[i] <= cfg_r[i].side_high;
                cfg_fet_p_o[i] <= cfg_r[i].fet_p;
            end
        end
    end

    // checks
    localparam int TSW = `OPD_TSW_GC_CYC;
    a_tri_when_off: assert property (@(posedge clk_i) disable iff (rst_all)
        !eff_en[0] |=> !gate_drive_oe_o[0] && !gate_pull_up_o[0] && !gate_pull_down_o[0])
        else $error("channel 0 drives while disabled");
    a_safety_and: assert property (@(posedge clk_i) disable iff (rst_all)
        !safety_s |=> !gate_drive_oe_o[`OPD_SAFETY_CH])
        else $error("safety channel enabled with pin low");
    a_sticky_set: assert property (@(posedge clk_i) disable iff (rst_all)
        cfg_r[`OPD_SAFETY_CH].out_en && !safety_s |=> safety_disable_sticky_o)
        else $error("sticky bit not set");
    a_sticky_clr: assert property (@(posedge clk_i) disable iff (rst_all)
        status_read_i && !(cfg_r[`OPD_SAFETY_CH].out_en && !safety_s)
        |=> !safety_disable_sticky_o)
        else $error("sticky bit not cleared on read");
    a_level_rpt: assert property (@(posedge clk_i) disable iff (rst_all)
        !$past(rst_all) |-> safety_enable_level_o == $past(safety_s))
        else $error("safety level wrong");
    a_pin_ctl: assert property (@(posedge clk_i) disable iff (rst_all)
        eff_en[1] && !cfg_r[1].src_soft && !cfg_r[1].fet_p
        |=> gate_pull_up_o[1] == !$past(pin_n_s[1]))
        else $error("pin control wrong");
    a_soft_ctl: assert property (@(posedge clk_i) disable iff (rst_all)
        eff_en[4] && cfg_r[4].src_soft && !cfg_r[4].fet_p
        |=> gate_pull_up_o[4] == $past(cfg_r[4].soft_on))
        else $error("soft control wrong");
    a_gcc_apply: assert property (@(posedge clk_i) disable iff (rst_all)
        $changed(cfg_r[3].gcc) |-> ##[1:TSW] gate_current_sel_o[7:6] == cfg_r[3].gcc)
        else $error("gate current code late");
    a_reset_off: assert property (@(posedge clk_i)
        rst_all |=> gate_drive_oe_o == '0 && !safety_disable_sticky_o)
        else $error("outputs live after reset");
    a_one_source: assert property (@(posedge clk_i) disable iff (rst_all)
        gate_drive_oe_o[4] |-> gate_pull_up_o[4] != gate_pull_down_o[4])
        else $error("gate drive not exclusive");
endmodule

// >>> sim/opd_host_model.sv
// host pin driver model for the pre-driver block
`timescale 1ns/1ps
module opd_host_model (
    // clock
    input wire logic clk_i,
    // requested levels
    input wire logic rst_n_req_i,
    input wire logic safe_req_i,
    input wire logic [7:0] pin_n_req_i,
    // pins
    output logic external_reset_n_o = 1'b1,
    output logic safety_enable_pin_o = 1'b0,
    output logic [7:0] pin_on_control_n_o = 8'hff
);
    // pins move just after an edge, as a host port would
    always @(posedge clk_i) begin
        external_reset_n_o <= rst_n_req_i;
        safety_enable_pin_o <= safe_req_i;
        pin_on_control_n_o <= pin_n_req_i;
    end
endmodule

// >>> sim/opd_predriver_tb_top.sv
// testbench for the output pre-driver control block
`timescale 1ns/1ps
module opd_predriver_tb_top;
    import opd_pkg::*;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [7:0] side = 8'h00, fet = 8'h00, oe = 8'h00, src = 8'h00, son = 8'h00;
    logic [15:0] gcc = 16'h0000;
    logic wr = 1'b0, rd = 1'b0, h_rst_n = 1'b1, h_safe = 1'b0;
    logic [7:0] h_pin_n = 8'hff;
    logic ext_rst_n, safe_pin, lvl, sticky;
    logic [7:0] pin_n, pu, pd, goe, c_side, c_fet, e_on;
    logic [15:0] gsel;
    int n_errors = 0;
    int cmp_count = 0;
    always #5 clk_i = ~clk_i;
    opd_host_model opd_host_model_i (.clk_i(clk_i), .rst_n_req_i(h_rst_n),
        .safe_req_i(h_safe), .pin_n_req_i(h_pin_n), .external_reset_n_o(ext_rst_n),
        .safety_enable_pin_o(safe_pin), .pin_on_control_n_o(pin_n));
    opd_predriver #(.NCH(8)) opd_predriver_i (.clk_i(clk_i), .srst_i(srst_i),
        .external_reset_n_i(ext_rst_n), .channel_side_select_i(side),
        .fet_type_select_i(fet), .channel_output_enable_i(oe),
        .control_source_select_i(src), .soft_on_command_i(son),
        .gate_current_code_i(gcc), .cfg_write_i(wr), .pin_on_control_n_i(pin_n),
        .safety_enable_pin_i(safe_pin), .status_read_i(rd),
        .safety_enable_level_o(lvl), .safety_disable_sticky_o(sticky),
        .gate_pull_up_o(pu), .gate_pull_down_o(pd), .gate_drive_oe_o(goe),
        .gate_current_sel_o(gsel), .cfg_side_high_o(c_side), .cfg_fet_p_o(c_fet));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic cfg(input logic [7:0] s, f, e, c, o, input logic [15:0] g);
        @(posedge clk_i);
        side <= s;
        fet <= f;
        oe <= e;
        src <= c;
        son <= o;
        gcc <= g;
        wr <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
        tick(2);
    endtask
    task automatic pins(input logic r, input logic s, input logic [7:0] p);
        @(posedge clk_i);
        h_rst_n <= r;
        h_safe <= s;
        h_pin_n <= p;
        tick(7);
    endtask
    task automatic t_reset();
        chk({goe, pu}, 16'h0000);
        chk({pd, c_side}, 16'h0000);
        chk({c_fet, 7'h00, sticky}, 16'h0000);
        chk(gsel, 16'h0000);
    endtask
    task automatic t_config();
        cfg(8'ha5, 8'h3c, 8'h00, 8'h00, 8'h00, 16'h1b4e);
        chk({c_side, c_fet}, 16'ha53c);
        chk(gsel, 16'h1b4e);
        chk(goe, 8'h00);
        cfg(8'ha5, 8'h3c, 8'h00, 8'h00, 8'h00, 16'he4b1);
        chk(gsel, 16'he4b1);
    endtask
    task automatic t_control();
        logic [7:0] p, s;
        pins(1'b1, 1'b1, 8'hff);
        for (int i = 0; i < 4; i++) begin
            p = i[0] ? 8'h55 : 8'haa;
            s = i[1] ? 8'h0f : 8'hf0;
            pins(1'b1, 1'b1, p);
            cfg(8'hc3, 8'h0f, 8'hff, 8'h33, s, 16'h0000);
            e_on = (8'h33 & s) | (~8'h33 & ~p);
            chk({goe, pu}, {8'hff, e_on ^ 8'h0f});
            chk({8'h00, pd}, {8'h00, ~(e_on ^ 8'h0f)});
        end
    endtask
    task automatic t_disable();
        pins(1'b1, 1'b1, 8'h00);
        cfg(8'h00, 8'h00, 8'h5a, 8'h00, 8'h00, 16'h0000);
        chk({goe, pu | pd}, 16'h5a5a);
    endtask
    task automatic t_safety();
        cfg(8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 16'h0000);
        chk({lvl, sticky, goe}, 16'h02ff);
        pins(1'b1, 1'b0, 8'h00);
        chk({lvl, sticky, goe}, 16'h01df);
        pins(1'b1, 1'b1, 8'h00);
        chk({lvl, sticky, goe}, 16'h03ff);
        @(posedge clk_i);
        rd <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        tick(2);
        chk({lvl, sticky}, 16'h0002);
    endtask
    task automatic t_ext_reset();
        pins(1'b0, 1'b1, 8'h00);
        chk({goe, pu | pd}, 16'h0000);
        chk({c_side, c_fet}, 16'h0000);
        pins(1'b1, 1'b1, 8'h00);
        cfg(8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 16'h0000);
        chk(goe, 8'hff);
    endtask
    task automatic end_of_test();
        $display("errors=%0d compares=%0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clk_i);
        n_errors++;
        end_of_test();
    end
    initial begin
        repeat (5) @(posedge clk_i);
        srst_i <= 1'b0;
        tick(6);
        t_reset();
        t_config();
        t_control();
        t_disable();
        t_safety();
        t_ext_reset();
        end_of_test();
    end
endmodule
